// [hw/bmf_core.sv]
// Block byte move engine and condition-code flag unit
// Functional notes
// - Word form copies bytes source to destination, stepping pointers, until count is zero.
// - Byte form counts with the low byte only; zero means no transfer.
// - A move takes eight states plus four per byte moved.
// - That figure holds only with no wait; other placements take longer.
// - Word arithmetic sets half-carry on carry or borrow at bit 11.
// - Longword arithmetic sets half-carry on carry or borrow at bit 27.
// - Extended add/subtract keeps zero flag on zero result, clears it otherwise.
// - Decimal adjust sets carry when adjustment carries, else keeps it.
// - Unsigned divide sets negative flag when divisor is negative.
// - Divide sets zero flag exactly when divisor is zero.
// - Signed divide sets negative flag when quotient is negative.
// - Transfers stretched by slow-clock synchronisation have variable length.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bmf_core (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Memory side
  output bmf_pkg::bmf_mem_req_type MEM_REQ,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_WAIT,
  // Status
  output logic MOVE_BUSY
);
  import bmf_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W out of range");
  end

  typedef enum {ST_IDLE, ST_PRE, ST_RDA, ST_RDB, ST_WRA, ST_WRB, ST_POST} bmf_state_type;
  bmf_state_type st_q;
  logic [1:0] ph_q;
  logic word_q, waited_q, done_q;
  logic [15:0] count_q, n_q, states_q, last_q;
  logic [ADDR_W-1:0] src_q, dst_q;
  logic [7:0] data_q;
  logic [31:0] opa_q, opb_q, res_q;
  logic [7:0] ccr_q;
  logic [1:0] sz_q;
  bmf_fop_type fop_q;
  logic go_q;

  logic wr_ctrl, start, step, more;
  logic [15:0] count_dec;
  assign wr_ctrl = REG_WR && REG_ADDR == A_CTRL;
  assign start = wr_ctrl && REG_WDATA[CTRL_START] && st_q == ST_IDLE;
  assign step = st_q == ST_WRB && !MEM_WAIT;
  assign count_dec = word_q ? count_q - 16'h1 : {count_q[15:8], count_q[7:0] - 8'h1};
  // Loop test after this byte, on the count about to be stored
  assign more = word_q ? count_dec != 16'h0 : count_dec[7:0] != 8'h0;

  // Move sequencer; the memory request is registered with the state
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      MEM_REQ <= '0;
      data_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_PRE;
            ph_q <= 2'h0;
          end
        end
        ST_PRE: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'(PRE_STATES - 1)) begin
            ph_q <= 2'h0;
            if (word_q ? count_q != 16'h0 : count_q[7:0] != 8'h0) begin
              st_q <= ST_RDA;
              MEM_REQ <= '{req: 1'b1, we: 1'b0, addr: src_q, wdata: 8'h00};
            end else begin
              st_q <= ST_POST;
            end
          end
        end
        ST_RDA: st_q <= ST_RDB;
        ST_RDB: begin
          // Held while the memory stretches the cycle
          if (!MEM_WAIT) begin
            data_q <= MEM_RDATA;
            st_q <= ST_WRA;
            MEM_REQ <= '{req: 1'b1, we: 1'b1, addr: dst_q, wdata: MEM_RDATA};
          end
        end
        ST_WRA: st_q <= ST_WRB;
        ST_WRB: begin
          if (!MEM_WAIT) begin
            if (more) begin
              st_q <= ST_RDA;
              MEM_REQ <= '{req: 1'b1, we: 1'b0, addr: src_q + ADDR_W'(1), wdata: 8'h00};
            end else begin
              st_q <= ST_POST;
              MEM_REQ <= '0;
            end
          end
        end
        ST_POST: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'(POST_STATES - 1)) begin
            st_q <= ST_IDLE;
            ph_q <= 2'h0;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Count and pointers; software writes are ignored during a move
  always_ff @(posedge CLK) begin
    if (RST) begin
      count_q <= 16'h0;
      src_q <= '0;
      dst_q <= '0;
      word_q <= 1'b0;
      n_q <= 16'h0;
    end else if (st_q == ST_IDLE) begin
      if (REG_WR && REG_ADDR == A_COUNT) count_q <= REG_WDATA[15:0];
      if (REG_WR && REG_ADDR == A_SRC) src_q <= REG_WDATA[ADDR_W-1:0];
      if (REG_WR && REG_ADDR == A_DST) dst_q <= REG_WDATA[ADDR_W-1:0];
      if (start) begin
        word_q <= REG_WDATA[CTRL_WORD];
        n_q <= REG_WDATA[CTRL_WORD] ? count_q : {8'h00, count_q[7:0]};
      end
    end else if (step) begin
      src_q <= src_q + ADDR_W'(1);
      dst_q <= dst_q + ADDR_W'(1);
      count_q <= count_dec;
    end
  end

  // State count of the move, kept for software
  always_ff @(posedge CLK) begin
    if (RST) begin
      states_q <= 16'h0;
      last_q <= 16'h0;
      waited_q <= 1'b0;
      MOVE_BUSY <= 1'b0;
    end else begin
      MOVE_BUSY <= start || (st_q != ST_IDLE && !(st_q == ST_POST && ph_q == 2'(POST_STATES - 1)));
      if (start) begin
        states_q <= 16'h0;
        waited_q <= 1'b0;
      end else if (st_q != ST_IDLE) begin
        states_q <= states_q + 16'h1;
      end
      // Wait states lengthen the move beyond the on-chip figure
      if ((st_q == ST_RDB || st_q == ST_WRB) && MEM_WAIT) waited_q <= 1'b1;
      if (st_q == ST_POST && ph_q == 2'(POST_STATES - 1)) last_q <= states_q + 16'h1;
    end
  end

  // Flag unit
  logic [5:0] w, w2;
  logic [31:0] m, m2, hm, a, b, r, mag_a, mag_b;
  logic [32:0] s, hs;
  logic [8:0] d9;
  logic [7:0] adj, ccr_d;
  logic cin, sa, sb, sr, hc, cy, sdv;
  always_comb begin
    w = sz_q == SZ_B ? 6'd8 : sz_q == SZ_W ? 6'd16 : 6'd32;
    w2 = sz_q == SZ_B ? 6'd16 : 6'd32;
    m = 32'hFFFFFFFF >> (6'd32 - w);
    m2 = 32'hFFFFFFFF >> (6'd32 - w2);
    hm = m >> 4;
    a = opa_q & m;
    b = opb_q & m;
    cin = (fop_q == FOP_ADDX || fop_q == FOP_SUBX) && ccr_q[CCR_C];
    if (fop_q == FOP_SUB || fop_q == FOP_SUBX) begin
      s = {1'b0, a} - {1'b0, b} - {32'h0, cin};
      hs = {1'b0, a & hm} - {1'b0, b & hm} - {32'h0, cin};
    end else begin
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      hs = {1'b0, a & hm} + {1'b0, b & hm} + {32'h0, cin};
    end
    // Half carry lands at bit 4, 12 or 28 for the three widths
    hc = hs[w - 6'd4];
    cy = s[w];
    r = s[31:0] & m;
    sa = a[5'(w - 6'd1)];
    sb = b[5'(w - 6'd1)];
    sr = r[5'(w - 6'd1)];
    adj = {((ccr_q[CCR_C] || opa_q[7:0] > 8'h99) ? 4'h6 : 4'h0),
           ((ccr_q[CCR_H] || opa_q[3:0] > 4'h9) ? 4'h6 : 4'h0)};
    d9 = {1'b0, opa_q[7:0]} + {1'b0, adj};
    mag_a = opa_q[5'(w2 - 6'd1)] ? (~opa_q + 32'h1) & m2 : opa_q & m2;
    mag_b = sb ? (~opb_q + 32'h1) & m : b;
    sdv = (opa_q[5'(w2 - 6'd1)] ^ sb) && b != 32'h0 && mag_a >= mag_b;
    ccr_d = ccr_q;
    case (fop_q)
      FOP_ADD, FOP_SUB, FOP_ADDX, FOP_SUBX: begin
        ccr_d[CCR_H] = hc;
        ccr_d[CCR_N] = sr;
        ccr_d[CCR_C] = cy;
        ccr_d[CCR_V] = (fop_q == FOP_ADD || fop_q == FOP_ADDX) ? (sa == sb && sr != sa) : (sa != sb && sr != sa);
        if (fop_q == FOP_ADDX || fop_q == FOP_SUBX) begin
          ccr_d[CCR_Z] = r == 32'h0 ? ccr_q[CCR_Z] : 1'b0;
        end else begin
          ccr_d[CCR_Z] = r == 32'h0;
        end
      end
      FOP_DAA: begin
        r = {24'h0, d9[7:0]};
        ccr_d[CCR_N] = d9[7];
        ccr_d[CCR_Z] = d9[7:0] == 8'h00;
        ccr_d[CCR_C] = ccr_q[CCR_C] | d9[8];
      end
      FOP_DIVU: begin
        r = 32'h0;
        ccr_d[CCR_N] = sb;
        ccr_d[CCR_Z] = b == 32'h0;
      end
      FOP_DIVS: begin
        r = 32'h0;
        ccr_d[CCR_N] = sdv;
        ccr_d[CCR_Z] = b == 32'h0;
      end
      default: ccr_d = ccr_q;
    endcase
  end

  // Operands, command and condition codes; the move path never touches them
  always_ff @(posedge CLK) begin
    if (RST) begin
      opa_q <= 32'h0;
      opb_q <= 32'h0;
      fop_q <= FOP_ADD;
      sz_q <= SZ_B;
      go_q <= 1'b0;
      ccr_q <= CCR_RST;
      res_q <= 32'h0;
    end else begin
      go_q <= REG_WR && REG_ADDR == A_FOP;
      if (REG_WR && REG_ADDR == A_OPA) opa_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == A_OPB) opb_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == A_FOP) begin
        fop_q <= bmf_fop_type'(REG_WDATA[3:0]);
        sz_q <= REG_WDATA[FOP_SZ_LSB+1:FOP_SZ_LSB];
      end
      if (go_q) begin
        ccr_q <= ccr_d;
        res_q <= r;
      end else if (REG_WR && REG_ADDR == A_CCR) begin
        ccr_q <= REG_WDATA[7:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        A_CTRL: REG_RDATA <= {30'h0, waited_q, MOVE_BUSY};
        A_COUNT: REG_RDATA <= {16'h0, count_q};
        A_SRC: REG_RDATA <= 32'(src_q);
        A_DST: REG_RDATA <= 32'(dst_q);
        A_STATES: REG_RDATA <= {16'h0, last_q};
        A_OPA: REG_RDATA <= opa_q;
        A_OPB: REG_RDATA <= opb_q;
        A_FOP: REG_RDATA <= {26'h0, sz_q, fop_q};
        A_CCR: REG_RDATA <= {24'h0, ccr_q};
        A_RES: REG_RDATA <= res_q;
        default: REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  // Checks
  logic [12:0] h12;
  logic [28:0] h28;
  assign h12 = {1'b0, opa_q[11:0]} + {1'b0, opb_q[11:0]};
  assign h28 = {1'b0, opa_q[27:0]} + {1'b0, opb_q[27:0]};

  a_move_states: assert property (@(posedge CLK) disable iff (RST)
    done_q && !waited_q |-> last_q == 16'(MOVE_BASE_STATES + MOVE_BYTE_STATES * n_q))
    else $error("move state count wrong");
  a_move_slow: assert property (@(posedge CLK) disable iff (RST)
    done_q && waited_q |-> last_q > 16'(MOVE_BASE_STATES + MOVE_BYTE_STATES * n_q))
    else $error("stretched move not longer");
  a_byte_zero: assert property (@(posedge CLK) disable iff (RST)
    st_q == ST_PRE && ph_q == 2'h3 && !word_q && count_q[7:0] == 8'h00 |=> st_q == ST_POST ##4 st_q == ST_IDLE)
    else $error("zero byte count moved data");
  a_ptr_step: assert property (@(posedge CLK) disable iff (RST)
    step |=> src_q == $past(src_q) + ADDR_W'(1) && dst_q == $past(dst_q) + ADDR_W'(1) && MEM_REQ.we == 1'b0)
    else $error("pointer step wrong");
  a_word_count: assert property (@(posedge CLK) disable iff (RST)
    step && word_q |=> count_q == $past(count_q) - 16'h1)
    else $error("count not decremented");
  a_wait_hold: assert property (@(posedge CLK) disable iff (RST)
    st_q == ST_RDB && MEM_WAIT |=> st_q == ST_RDB && MEM_REQ.req)
    else $error("read did not wait");
  a_ccr_frozen: assert property (@(posedge CLK) disable iff (RST)
    MOVE_BUSY && !go_q && !(REG_WR && REG_ADDR == A_CCR) |=> $stable(ccr_q))
    else $error("move changed flags");
  a_hc_word: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q == FOP_ADD && sz_q == SZ_W |=> ccr_q[CCR_H] == $past(h12[12]))
    else $error("word half carry wrong");
  a_hc_long: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q == FOP_ADD && sz_q == SZ_L |=> ccr_q[CCR_H] == $past(h28[28]))
    else $error("long half carry wrong");
  a_ext_zero: assert property (@(posedge CLK) disable iff (RST)
    go_q && (fop_q == FOP_ADDX || fop_q == FOP_SUBX) |=> ccr_q[CCR_Z] == ($past(ccr_q[CCR_Z]) && res_q == 32'h0))
    else $error("extended zero flag wrong");
  a_daa_carry: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q == FOP_DAA && ccr_q[CCR_C] |=> ccr_q[CCR_C])
    else $error("adjust lost carry");
  a_div_zero: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q inside {FOP_DIVU, FOP_DIVS} && sz_q == SZ_B |=> ccr_q[CCR_Z] == ($past(opb_q[7:0]) == 8'h00))
    else $error("divide zero flag wrong");
  a_divu_neg: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q == FOP_DIVU && sz_q == SZ_B |=> ccr_q[CCR_N] == $past(opb_q[7]))
    else $error("divisor sign flag wrong");
  a_divs_neg: assert property (@(posedge CLK) disable iff (RST)
    go_q && fop_q == FOP_DIVS && sz_q == SZ_B && opb_q[7:0] == 8'h01 |=> ccr_q[CCR_N] == $past(opa_q[15]))
    else $error("quotient sign flag wrong");
  a_wr_data: assert property (@(posedge CLK) disable iff (RST)
    st_q == ST_WRA |-> MEM_REQ.req && MEM_REQ.we && MEM_REQ.addr == dst_q && MEM_REQ.wdata == data_q)
    else $error("move write request wrong");
  c_zero_move: cover property (@(posedge CLK) disable iff (RST) done_q && n_q == 16'h0);
  c_two_bytes: cover property (@(posedge CLK) disable iff (RST) done_q && n_q == 16'h2 && word_q);
  c_waited: cover property (@(posedge CLK) disable iff (RST) done_q && waited_q);
  c_daa_carry: cover property (@(posedge CLK) disable iff (RST) go_q && fop_q == FOP_DAA && ccr_d[CCR_C]);
endmodule
`default_nettype wire

// [hw/bmf_pkg.sv]
// Package: register map, field layout, timing and types of the block-move and flag unit
package bmf_pkg;
  localparam int ADDR_W = 16;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_COUNT = 8'h04;
  localparam logic [7:0] A_SRC = 8'h08;
  localparam logic [7:0] A_DST = 8'h0C;
  localparam logic [7:0] A_STATES = 8'h10;
  localparam logic [7:0] A_OPA = 8'h14;
  localparam logic [7:0] A_OPB = 8'h18;
  localparam logic [7:0] A_FOP = 8'h1C;
  localparam logic [7:0] A_CCR = 8'h20;
  localparam logic [7:0] A_RES = 8'h24;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTRL_BUSY = 0;
  localparam int CTRL_WAITED = 1;
  localparam int FOP_SZ_LSB = 4;
  // Condition-code bit positions
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_H = 5;
  localparam logic [7:0] CCR_RST = 8'h80;
  // Operand sizes
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  // Move timing in states
  localparam int MOVE_BASE_STATES = 8;
  localparam int MOVE_BYTE_STATES = 4;
  localparam int PRE_STATES = MOVE_BASE_STATES / 2;
  localparam int POST_STATES = MOVE_BASE_STATES - PRE_STATES;
  typedef enum logic [3:0] {FOP_ADD, FOP_SUB, FOP_ADDX, FOP_SUBX, FOP_DAA, FOP_DIVU, FOP_DIVS} bmf_fop_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } bmf_mem_req_type;
endpackage

// [verification/bmf_mem_model.sv]
// Byte-wide memory model on the far side of the block mover, with optional wait stretching
`timescale 1ns/1ps
`default_nettype none
module bmf_mem_model (
  // Clock
  input wire logic CLK,
  // Wait stretching enable
  input wire logic SLOW,
  // Memory bus
  input wire bmf_pkg::bmf_mem_req_type MEM_REQ,
  output logic [7:0] MEM_RDATA,
  output logic MEM_WAIT
);
  import bmf_pkg::*;
  logic [7:0] mem [0:255];
  logic ph_q = 1'b0;
  logic [7:0] rdata_q = 8'h00;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(3 * i + 1);
    end
  end
  // Free-running phase, so the stretch depends on where an access lands
  assign MEM_WAIT = SLOW & MEM_REQ.req & ph_q;
  assign MEM_RDATA = rdata_q;
  always @(posedge CLK) begin
    ph_q <= ~ph_q;
    // Idle data line keeps changing so a stale sample is caught
    rdata_q <= (MEM_REQ.req && !MEM_REQ.we) ? mem[MEM_REQ.addr[7:0]] : ~rdata_q;
    if (MEM_REQ.req && MEM_REQ.we && !MEM_WAIT) begin
      mem[MEM_REQ.addr[7:0]] <= MEM_REQ.wdata;
    end
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the block-move and flag unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  import bmf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata;
  bmf_mem_req_type mem_req;
  logic [7:0] mem_rdata;
  logic mem_wait;
  logic move_busy;
  int n_errors = 0;
  int checks_done = 0;
  int cyc;
  logic [31:0] rv;
  bmf_core u_bmf_core (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .MEM_WAIT(mem_wait),
    .MOVE_BUSY(move_busy));
  bmf_mem_model u_bmf_mem_model (.CLK(clk), .SLOW(slow), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata),
    .MEM_WAIT(mem_wait));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] pat(input int a);
    return 8'(3 * a + 1);
  endfunction
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    `CHK(nm, e, rv)
  endtask
  // Poke writes count and start during the move; both must be ignored
  task automatic do_move(input logic [15:0] s, input logic [15:0] d, input logic [15:0] c, input logic [31:0] ctl,
                         input bit poke);
    wr(A_SRC, {16'h0, s});
    wr(A_DST, {16'h0, d});
    wr(A_COUNT, {16'h0, c});
    wr(A_CTRL, ctl);
    cyc = 0;
    if (poke) begin
      wr(A_COUNT, 32'h9);
      wr(A_CTRL, 32'h1);
      cyc = 4;
    end
    #1;
    while (move_busy === 1'b1) begin
      cyc++;
      if (cyc > 500) begin
        n_errors++;
        give_verdict();
      end
      @(posedge clk);
      #1;
    end
  endtask
  // Only CCR bits under mask m are compared
  task automatic flg(input bmf_fop_type op, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] b,
                     input logic [7:0] pre, input logic [7:0] m, input logic [7:0] e);
    wr(A_CCR, {24'h0, pre});
    wr(A_OPA, a);
    wr(A_OPB, b);
    wr(A_FOP, {26'h0, sz, op});
    repeat (2) @(posedge clk);
    rd(A_CCR, rv);
    `CHK("ccr", {24'h0, e}, rv & {24'h0, m})
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_rd("ccr_rst", A_CCR, {24'h0, CCR_RST});
    chk_rd("states_rst", A_STATES, 32'h0);
    wr(8'h30, 32'h5A);
    chk_rd("unmapped", 8'h30, 32'h0);
    wr(A_CCR, 32'hAD);
    do_move(16'h10, 16'h40, 16'h3, 32'h3, 1'b0);
    `CHK("cyc_w", MOVE_BASE_STATES + 3 * MOVE_BYTE_STATES, cyc)
    chk_rd("states_w", A_STATES, 32'(MOVE_BASE_STATES + 3 * MOVE_BYTE_STATES));
    for (int i = 0; i < 3; i++) `CHK("dst_w", pat(8'h10 + i), u_bmf_mem_model.mem[8'h40 + i])
    `CHK("dst_w_end", pat(8'h43), u_bmf_mem_model.mem[8'h43])
    chk_rd("src_w", A_SRC, 32'h13);
    chk_rd("dptr_w", A_DST, 32'h43);
    chk_rd("cnt_w", A_COUNT, 32'h0);
    chk_rd("ccr_mv", A_CCR, 32'hAD);
    do_move(16'h20, 16'h50, 16'h0102, 32'h1, 1'b0);
    `CHK("cyc_b", MOVE_BASE_STATES + 2 * MOVE_BYTE_STATES, cyc)
    for (int i = 0; i < 2; i++) `CHK("dst_b", pat(8'h20 + i), u_bmf_mem_model.mem[8'h50 + i])
    `CHK("dst_b_end", pat(8'h52), u_bmf_mem_model.mem[8'h52])
    chk_rd("cnt_b", A_COUNT, 32'h0100);
    do_move(16'h28, 16'h60, 16'h0100, 32'h1, 1'b0);
    `CHK("cyc_0", MOVE_BASE_STATES, cyc)
    `CHK("dst_0", pat(8'h60), u_bmf_mem_model.mem[8'h60])
    chk_rd("states_0", A_STATES, 32'(MOVE_BASE_STATES));
    slow <= 1'b1;
    do_move(16'h30, 16'h70, 16'h2, 32'h3, 1'b1);
    `CHK("wait_long", 1'b1, cyc > MOVE_BASE_STATES + 2 * MOVE_BYTE_STATES)
    chk_rd("waited", A_CTRL, 32'h2);
    chk_rd("cnt_poke", A_COUNT, 32'h0);
    for (int i = 0; i < 2; i++) `CHK("dst_s", pat(8'h30 + i), u_bmf_mem_model.mem[8'h70 + i])
    slow <= 1'b0;
    chk_rd("ccr_mv2", A_CCR, 32'hAD);
    flg(FOP_ADD, SZ_W, 32'h800, 32'h800, 8'h00, 8'h20, 8'h20);
    flg(FOP_ADD, SZ_W, 32'h88, 32'h88, 8'h20, 8'h20, 8'h00);
    flg(FOP_SUB, SZ_W, 32'h1000, 32'h1, 8'h00, 8'h20, 8'h20);
    flg(FOP_ADD, SZ_L, 32'h8000000, 32'h8000000, 8'h00, 8'h20, 8'h20);
    flg(FOP_ADD, SZ_L, 32'h800, 32'h800, 8'h20, 8'h20, 8'h00);
    flg(FOP_ADDX, SZ_B, 32'h0, 32'h0, 8'h04, 8'h04, 8'h04);
    flg(FOP_ADDX, SZ_B, 32'h0, 32'h0, 8'h00, 8'h04, 8'h00);
    flg(FOP_ADDX, SZ_B, 32'h1, 32'h0, 8'h04, 8'h04, 8'h00);
    flg(FOP_SUBX, SZ_W, 32'h5, 32'h5, 8'h04, 8'h04, 8'h04);
    flg(FOP_DAA, SZ_B, 32'h12, 32'h0, 8'h01, 8'h01, 8'h01);
    flg(FOP_DAA, SZ_B, 32'h9A, 32'h0, 8'h00, 8'h01, 8'h01);
    chk_rd("res_daa", A_RES, 32'h0);
    flg(FOP_DAA, SZ_B, 32'h12, 32'h0, 8'h00, 8'h01, 8'h00);
    flg(FOP_DIVU, SZ_B, 32'h10, 32'h80, 8'h00, 8'h08, 8'h08);
    flg(FOP_DIVU, SZ_B, 32'h10, 32'h05, 8'h08, 8'h08, 8'h00);
    flg(FOP_DIVU, SZ_B, 32'h10, 32'h0, 8'h00, 8'h04, 8'h04);
    flg(FOP_DIVS, SZ_B, 32'h10, 32'h05, 8'h04, 8'h04, 8'h00);
    flg(FOP_DIVS, SZ_B, 32'h10, 32'hFE, 8'h00, 8'h08, 8'h08);
    flg(FOP_DIVS, SZ_B, 32'h1, 32'hFE, 8'h08, 8'h08, 8'h00);
    flg(FOP_DIVS, SZ_B, 32'hFFF0, 32'hFE, 8'h08, 8'h08, 8'h00);
    flg(FOP_DIVS, SZ_B, 32'hFF80, 32'h01, 8'h00, 8'h08, 8'h08);
    give_verdict();
  end
endmodule
`default_nettype wire
